/* File: rtl/link_serializer_ctrl_pkg.sv */
package link_serializer_ctrl_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] MASTER_SCL_HIGH_COUNT_ADDR        = 8'h18;
	localparam logic [7:0] MASTER_SCL_LOW_COUNT_ADDR         = 8'h19;
	localparam logic [7:0] DATAPATH_CONTROL_SECOND_ADDR      = 8'h1A;
	localparam logic [7:0] BACKCHANNEL_BIST_ERROR_COUNT_ADDR = 8'h1B;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int         SECONDARY_AUDIO_BIT   = 3;
	localparam int         WIDE_PAYLOAD_BIT      = 1;
	localparam int         SURROUND_BIT          = 0;
	localparam logic [7:0] SCL_COUNT_RESET       = 8'h7F;
	localparam logic       WIDE_PAYLOAD_RESET    = 1'b0;
	localparam logic       SURROUND_RESET        = 1'b0;
	localparam logic [7:0] ERROR_COUNT_RESET     = 8'h00;
	localparam logic [7:0] ERROR_COUNT_MAX       = 8'hFF;
	localparam logic [7:0] READ_ZERO             = 8'h00;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int         CLK_FREQ_HZ           = 100_000_000;
	localparam int         OSC_NOMINAL_HZ        = 25_000_000;
	localparam int         OSC_DIV_CYCLES        = CLK_FREQ_HZ / OSC_NOMINAL_HZ;
	localparam logic [8:0] SCL_EXTRA_OSC_PERIODS = 9'h005;

	// ****************************************************************
	// States
	// ****************************************************************
	typedef enum logic [1:0] {
		SCL_IDLE,
		SCL_HIGH,
		SCL_LOW
	} scl_state_t;

	typedef enum logic [1:0] {
		SETUP_IDLE,
		SETUP_WAIT,
		SETUP_RELEASE
	} setup_state_t;

endpackage

/* File: rtl/link_serializer_ctrl_regs.sv */
`timescale 1ns/1ps
module link_serializer_ctrl_regs #(
	parameter int NUM_PORTS = 2
) (
	input  wire logic       clk_in,
	input  wire logic       reset_n_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic       reg_write_in,
	input  wire logic [7:0] reg_write_data_in,
	input  wire logic       reg_read_in,
	output logic      [7:0] reg_read_data_out,
	output logic            reg_read_valid_out,
	input  wire logic       master_enable_in,
	output logic            master_scl_out,
	output logic            master_scl_oe_n_out,
	input  wire logic       slave_data_presented_in,
	output logic            slave_scl_release_out,
	input  wire logic       aux_audio_enable_in,
	output logic            wide_payload_mode_out,
	input  wire logic       repeater_mode_in,
	input  wire logic       inband_surround_in,
	output logic            surround_audio_out,
	output logic            data_island_transport_out,
	input  wire logic       bist_enable_in,
	input  wire logic       error_count_clear_in,
	input  wire logic       second_port_select_in,
	input  wire logic [1:0] backchannel_crc_error_in
);

	// ****************************************************************
	// Oscillator tick divider
	// ****************************************************************
	localparam int DIV_W = $clog2(link_serializer_ctrl_pkg::OSC_DIV_CYCLES);

	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_d;
	logic             osc_tick;

	always_comb begin
		osc_tick = (div_q == DIV_W'(link_serializer_ctrl_pkg::OSC_DIV_CYCLES - 1));
		div_d    = osc_tick ? '0 : div_q + DIV_W'(1);
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	// ****************************************************************
	// Register file
	// ****************************************************************
	logic [7:0] scl_high_q;
	logic [7:0] scl_high_d;
	logic [7:0] scl_low_q;
	logic [7:0] scl_low_d;
	logic       wide_q;
	logic       wide_d;
	logic       surround_q;
	logic       surround_d;
	logic       surround_eff_q;
	logic       surround_eff_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       rvalid_q;
	logic [7:0] err_count_q [NUM_PORTS];
	logic [7:0] err_count_d [NUM_PORTS];
	logic [7:0] err_selected;

	always_comb begin
		scl_high_d     = scl_high_q;
		scl_low_d      = scl_low_q;
		wide_d         = wide_q;
		surround_d     = surround_q;
		if (reg_write_in) begin
			case (reg_addr_in)
				link_serializer_ctrl_pkg::MASTER_SCL_HIGH_COUNT_ADDR: begin
					scl_high_d = reg_write_data_in;
				end
				link_serializer_ctrl_pkg::MASTER_SCL_LOW_COUNT_ADDR: begin
					scl_low_d = reg_write_data_in;
				end
				link_serializer_ctrl_pkg::DATAPATH_CONTROL_SECOND_ADDR: begin
					// Only the two writable bits land; the status bit ignores writes
					wide_d     = reg_write_data_in[link_serializer_ctrl_pkg::WIDE_PAYLOAD_BIT];
					surround_d = reg_write_data_in[link_serializer_ctrl_pkg::SURROUND_BIT];
				end
				default: begin
					scl_high_d = scl_high_q;
				end
			endcase
		end
		// A repeater follows the in-band detection, not the written bit
		surround_eff_d = repeater_mode_in ? inband_surround_in : surround_d;
	end

	always_comb begin
		err_selected = err_count_q[0];
		if (second_port_select_in && NUM_PORTS > 1) begin
			err_selected = err_count_q[NUM_PORTS-1];
		end
		rdata_d = rdata_q;
		if (reg_read_in) begin
			case (reg_addr_in)
				link_serializer_ctrl_pkg::MASTER_SCL_HIGH_COUNT_ADDR: begin
					rdata_d = scl_high_q;
				end
				link_serializer_ctrl_pkg::MASTER_SCL_LOW_COUNT_ADDR: begin
					rdata_d = scl_low_q;
				end
				link_serializer_ctrl_pkg::DATAPATH_CONTROL_SECOND_ADDR: begin
					rdata_d = link_serializer_ctrl_pkg::READ_ZERO;
					rdata_d[link_serializer_ctrl_pkg::SECONDARY_AUDIO_BIT] = aux_audio_enable_in;
					rdata_d[link_serializer_ctrl_pkg::WIDE_PAYLOAD_BIT]    = wide_q;
					rdata_d[link_serializer_ctrl_pkg::SURROUND_BIT]        = surround_q;
				end
				link_serializer_ctrl_pkg::BACKCHANNEL_BIST_ERROR_COUNT_ADDR: begin
					rdata_d = err_selected;
				end
				default: begin
					rdata_d = link_serializer_ctrl_pkg::READ_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			scl_high_q     <= link_serializer_ctrl_pkg::SCL_COUNT_RESET;
			scl_low_q      <= link_serializer_ctrl_pkg::SCL_COUNT_RESET;
			wide_q         <= link_serializer_ctrl_pkg::WIDE_PAYLOAD_RESET;
			surround_q     <= link_serializer_ctrl_pkg::SURROUND_RESET;
			surround_eff_q <= link_serializer_ctrl_pkg::SURROUND_RESET;
			rdata_q        <= link_serializer_ctrl_pkg::READ_ZERO;
			rvalid_q       <= 1'b0;
		end else begin
			scl_high_q     <= scl_high_d;
			scl_low_q      <= scl_low_d;
			wide_q         <= wide_d;
			surround_q     <= surround_d;
			surround_eff_q <= surround_eff_d;
			rdata_q        <= rdata_d;
			rvalid_q       <= reg_read_in;
		end
	end

	// ****************************************************************
	// BIST back-channel error counters
	// ****************************************************************
	logic bist_q;
	logic bist_start;

	always_comb begin
		bist_start = bist_enable_in && !bist_q;
	end

	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_err
			always_comb begin
				err_count_d[p] = err_count_q[p];
				if (bist_start || error_count_clear_in) begin
					err_count_d[p] = link_serializer_ctrl_pkg::ERROR_COUNT_RESET;
				end
				// An error in the clearing cycle still counts, so none is lost
				if (bist_enable_in && backchannel_crc_error_in[p]) begin
					if (err_count_d[p] != link_serializer_ctrl_pkg::ERROR_COUNT_MAX) begin
						err_count_d[p] = err_count_d[p] + 8'h01;
					end
				end
			end

			always_ff @(posedge clk_in) begin
				if (!reset_n_in) begin
					err_count_q[p] <= link_serializer_ctrl_pkg::ERROR_COUNT_RESET;
				end else begin
					err_count_q[p] <= err_count_d[p];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			bist_q <= 1'b0;
		end else begin
			bist_q <= bist_enable_in;
		end
	end

	// ****************************************************************
	// Master SCL generator
	// ****************************************************************
	link_serializer_ctrl_pkg::scl_state_t scl_state_q;
	link_serializer_ctrl_pkg::scl_state_t scl_state_d;
	logic [8:0] scl_cnt_q;
	logic [8:0] scl_cnt_d;
	logic [8:0] high_limit;
	logic [8:0] low_limit;
	logic       scl_oe_n_d;
	logic       scl_oe_n_q;

	always_comb begin
		high_limit      = {1'b0, scl_high_q} + link_serializer_ctrl_pkg::SCL_EXTRA_OSC_PERIODS;
		low_limit       = {1'b0, scl_low_q} + link_serializer_ctrl_pkg::SCL_EXTRA_OSC_PERIODS;
		scl_state_d     = scl_state_q;
		scl_cnt_d       = scl_cnt_q;
		case (scl_state_q)
			link_serializer_ctrl_pkg::SCL_IDLE: begin
				scl_cnt_d = '0;
				if (master_enable_in) begin
					scl_state_d = link_serializer_ctrl_pkg::SCL_HIGH;
				end
			end
			link_serializer_ctrl_pkg::SCL_HIGH: begin
				if (osc_tick) begin
					scl_cnt_d = scl_cnt_q + 9'h001;
					if (scl_cnt_d >= high_limit) begin
						scl_cnt_d   = '0;
						scl_state_d = master_enable_in ? link_serializer_ctrl_pkg::SCL_LOW
							: link_serializer_ctrl_pkg::SCL_IDLE;
					end
				end
			end
			link_serializer_ctrl_pkg::SCL_LOW: begin
				// Low phase always completes so the bus never sees a runt pulse
				if (osc_tick) begin
					scl_cnt_d = scl_cnt_q + 9'h001;
					if (scl_cnt_d >= low_limit) begin
						scl_cnt_d   = '0;
						scl_state_d = link_serializer_ctrl_pkg::SCL_HIGH;
					end
				end
			end
			default: begin
				scl_state_d = link_serializer_ctrl_pkg::SCL_IDLE;
				scl_cnt_d   = '0;
			end
		endcase
		scl_oe_n_d      = (scl_state_d != link_serializer_ctrl_pkg::SCL_LOW);
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			scl_state_q     <= link_serializer_ctrl_pkg::SCL_IDLE;
			scl_cnt_q       <= '0;
			scl_oe_n_q      <= 1'b1;
		end else begin
			scl_state_q     <= scl_state_d;
			scl_cnt_q       <= scl_cnt_d;
			scl_oe_n_q      <= scl_oe_n_d;
		end
	end

	// ****************************************************************
	// Slave SDA setup before SCL release
	// ****************************************************************
	link_serializer_ctrl_pkg::setup_state_t setup_state_q;
	link_serializer_ctrl_pkg::setup_state_t setup_state_d;
	logic [8:0] setup_cnt_q;
	logic [8:0] setup_cnt_d;
	logic       release_q;

	always_comb begin
		setup_state_d = setup_state_q;
		setup_cnt_d   = setup_cnt_q;
		case (setup_state_q)
			link_serializer_ctrl_pkg::SETUP_IDLE: begin
				setup_cnt_d = '0;
				if (slave_data_presented_in) begin
					setup_state_d = link_serializer_ctrl_pkg::SETUP_WAIT;
				end
			end
			link_serializer_ctrl_pkg::SETUP_WAIT: begin
				if (osc_tick) begin
					setup_cnt_d = setup_cnt_q + 9'h001;
					if (setup_cnt_d > low_limit) begin // Extra tick covers a partial first tick
						setup_state_d = link_serializer_ctrl_pkg::SETUP_RELEASE;
					end
				end
			end
			link_serializer_ctrl_pkg::SETUP_RELEASE: begin
				setup_cnt_d   = '0;
				setup_state_d = link_serializer_ctrl_pkg::SETUP_IDLE;
			end
			default: begin
				setup_state_d = link_serializer_ctrl_pkg::SETUP_IDLE;
				setup_cnt_d   = '0;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			setup_state_q <= link_serializer_ctrl_pkg::SETUP_IDLE;
			setup_cnt_q   <= '0;
			release_q     <= 1'b0;
		end else begin
			setup_state_q <= setup_state_d;
			setup_cnt_q   <= setup_cnt_d;
			release_q     <= (setup_state_d == link_serializer_ctrl_pkg::SETUP_RELEASE);
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	always_comb begin
		reg_read_data_out         = rdata_q;
		reg_read_valid_out        = rvalid_q;
		master_scl_out            = 1'b0;
		master_scl_oe_n_out       = scl_oe_n_q;
		slave_scl_release_out     = release_q;
		wide_payload_mode_out     = wide_q;
		surround_audio_out        = surround_eff_q;
		data_island_transport_out = surround_eff_q;
	end

endmodule

/* File: dv/link_serializer_ctrl_regs_assertions.sv */
`timescale 1ns/1ps
module link_serializer_ctrl_regs_checker (
	input wire logic       clk_in,
	input wire logic       reset_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic       reg_write_in,
	input wire logic       reg_read_in,
	input wire logic [7:0] reg_read_data_out,
	input wire logic       master_scl_out,
	input wire logic       master_scl_oe_n_out,
	input wire logic       slave_data_presented_in,
	input wire logic       slave_scl_release_out,
	input wire logic       aux_audio_enable_in,
	input wire logic       wide_payload_mode_out,
	input wire logic       repeater_mode_in,
	input wire logic       inband_surround_in,
	input wire logic       surround_audio_out,
	input wire logic       data_island_transport_out
);
	// ****
	// Checks
	// ****
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	// Five ticks of four clocks make any phase longer than eight clocks
	sequence held_low; !master_scl_oe_n_out [*8]; endsequence
	sequence held_high; master_scl_oe_n_out [*8]; endsequence
	scl_level_a: assert property (master_scl_out == 1'b0) else $error("scl level");
	scl_high_a: assert property ($rose(master_scl_oe_n_out) |=> held_high) else $error("high short");
	scl_low_a: assert property ($fell(master_scl_oe_n_out) |=> held_low) else $error("low short");
	setup_wait_a: assert property (slave_data_presented_in |=> !slave_scl_release_out [*8])
		else $error("release early");
	release_pulse_a: assert property (slave_scl_release_out |=> !slave_scl_release_out) else $error("release");
	status_read_a: assert property (reg_read_in && reg_addr_in == link_serializer_ctrl_pkg::DATAPATH_CONTROL_SECOND_ADDR
		|=> reg_read_data_out[7:2] == {4'h0, $past(aux_audio_enable_in), 1'b0}) else $error("status");
	wide_hold_a: assert property (!reg_write_in |=> $stable(wide_payload_mode_out)) else $error("wide");
	island_tie_a: assert property (data_island_transport_out == surround_audio_out) else $error("island");
	repeater_ovr_a: assert property (repeater_mode_in && $past(reset_n_in)
		|=> surround_audio_out == $past(inband_surround_in)) else $error("override");
	unmapped_zero_a: assert property (reg_read_in && (reg_addr_in < 8'h18 || reg_addr_in > 8'h1B)
		|=> reg_read_data_out == 8'h00) else $error("unmapped");
endmodule
bind link_serializer_ctrl_regs link_serializer_ctrl_regs_checker i_checker (.*);

/* File: dv/i2c_bus_partner.sv */
`timescale 1ns/1ps
module i2c_bus_partner (
	input  wire logic clk_in,
	input  wire logic scl_oe_n_in,
	input  wire logic present_req_in,
	output logic      slave_present_out,
	output int        high_len_out,
	output int        low_len_out
);
	logic scl_wire;
	logic last_q;
	int   run_q;
	// Pull-up: a released line reads high
	assign scl_wire = scl_oe_n_in ? 1'b1 : 1'b0;
	always_ff @(posedge clk_in) begin
		last_q <= scl_wire;
		run_q <= (scl_wire == last_q) ? run_q + 1 : 1;
		if (scl_wire != last_q) begin
			if (last_q)
				high_len_out <= run_q;
			else
				low_len_out <= run_q;
		end
		slave_present_out <= present_req_in;
	end
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic       clk_in, reset_n_in, reg_write_in, reg_read_in, master_enable_in, aux_audio_enable_in;
	logic       repeater_mode_in, inband_surround_in, bist_enable_in, error_count_clear_in;
	logic       second_port_select_in, present_req, slave_data_presented_in;
	logic       reg_read_valid_out, master_scl_out, master_scl_oe_n_out, slave_scl_release_out;
	logic       wide_payload_mode_out, surround_audio_out, data_island_transport_out;
	logic [7:0] reg_addr_in, reg_write_data_in, reg_read_data_out;
	logic [1:0] backchannel_crc_error_in;
	int         errors, compares, cycles, n, high_len, low_len;
	link_serializer_ctrl_regs i_dut (.*);
	i2c_bus_partner i_bus (.clk_in(clk_in), .scl_oe_n_in(master_scl_oe_n_out), .present_req_in(present_req),
		.slave_present_out(slave_data_presented_in), .high_len_out(high_len), .low_len_out(low_len));
	// ****
	// Tasks
	// ****
	initial begin
		clk_in = 0;
		forever #5 clk_in = ~clk_in;
	end
	// Run takes under a thousand cycles
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step();
		@(posedge clk_in);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		step();
		reg_addr_in = a;
		reg_write_data_in = d;
		reg_write_in = 1;
		step();
		reg_write_in = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		step();
		reg_addr_in = a;
		reg_read_in = 1;
		step();
		reg_read_in = 0;
		chk("read valid", 8'h01, {7'h00, reg_read_valid_out});
		chk(what, exp, reg_read_data_out);
	endtask
	// ****
	// Tests
	// ****
	initial begin
		{reg_write_in, reg_read_in, master_enable_in, repeater_mode_in, inband_surround_in} = 0;
		{bist_enable_in, error_count_clear_in, second_port_select_in, present_req, reset_n_in} = 0;
		{reg_addr_in, reg_write_data_in, backchannel_crc_error_in} = 0;
		aux_audio_enable_in = 1;
		repeat (10) @(posedge clk_in);
		#1 reset_n_in = 1;
		rd(8'h18, 8'h7F, "high count");
		rd(8'h19, 8'h7F, "low count");
		rd(8'h1A, 8'h08, "path control");
		rd(8'h1B, 8'h00, "error count");
		rd(8'h30, 8'h00, "unmapped");
		$display("test reset done");
		wr(8'h18, 8'h03);
		wr(8'h19, 8'h02);
		wr(8'h1B, 8'h55);
		wr(8'h1A, 8'hFF);
		rd(8'h18, 8'h03, "high count");
		rd(8'h19, 8'h02, "low count");
		rd(8'h1B, 8'h00, "error count");
		rd(8'h1A, 8'h0B, "path control");
		chk("modes", 8'h07, {5'h00, wide_payload_mode_out, surround_audio_out, data_island_transport_out});
		aux_audio_enable_in = 0;
		wr(8'h1A, 8'h00);
		rd(8'h1A, 8'h00, "path control");
		chk("modes", 8'h00, {5'h00, wide_payload_mode_out, surround_audio_out, data_island_transport_out});
		{repeater_mode_in, inband_surround_in} = 2'b11;
		repeat (2) step();
		chk("override", 8'h03, {6'h00, surround_audio_out, data_island_transport_out});
		repeater_mode_in = 0;
		repeat (2) step();
		chk("override", 8'h00, {6'h00, surround_audio_out, data_island_transport_out});
		$display("test control done");
		master_enable_in = 1;
		repeat (150) step();
		chk("high clocks", 8'h20, high_len[7:0]);
		chk("low clocks", 8'h1C, low_len[7:0]);
		while (!master_scl_oe_n_out) step();
		master_enable_in = 0;
		present_req = 1;
		step();
		present_req = 0;
		n = 0;
		while (!slave_scl_release_out && n < 100) begin
			step();
			n++;
		end
		chk("setup wait", 8'h01, {7'h00, n >= 28 && n <= 34});
		$display("test scl done");
		backchannel_crc_error_in = 2'b11;
		repeat (2) step();
		backchannel_crc_error_in = 0;
		rd(8'h1B, 8'h00, "count bist off");
		bist_enable_in = 1;
		step();
		backchannel_crc_error_in = 2'b11;
		step();
		backchannel_crc_error_in = 2'b01;
		repeat (2) step();
		backchannel_crc_error_in = 0;
		rd(8'h1B, 8'h03, "port0 count");
		second_port_select_in = 1;
		rd(8'h1B, 8'h01, "port1 count");
		second_port_select_in = 0;
		backchannel_crc_error_in = 2'b01;
		repeat (260) step();
		backchannel_crc_error_in = 0;
		rd(8'h1B, 8'hFF, "saturated");
		error_count_clear_in = 1;
		step();
		error_count_clear_in = 0;
		rd(8'h1B, 8'h00, "cleared");
		backchannel_crc_error_in = 2'b01;
		step();
		{backchannel_crc_error_in, bist_enable_in} = 0;
		step();
		bist_enable_in = 1;
		rd(8'h1B, 8'h00, "restart");
		$display("test counter done");
		print_verdict();
	end
endmodule
